// *** verilog/bms_consts.svh ***
// constants for the boot mode select block
`ifndef BMS_CONSTS_SVH
`define BMS_CONSTS_SVH

// register offsets (byte addresses, one word each)
`define BMS_ADDR_W 8
`define BMS_OFS_FUSED_PIN 8'h00
`define BMS_OFS_TRIAL_PIN 8'h04
`define BMS_OFS_CTRL 8'h08
`define BMS_OFS_STATUS 8'h0C
`define BMS_OFS_TRIAL_DEF 8'h10
`define BMS_OFS_FUSED_DEF 8'h30
`define BMS_DEF_STRIDE 8'h04

// pin-selection word layout
`define BMS_KEY_LSB 24
`define BMS_KEY_VALUE 8'h5A
`define BMS_FIELD_W 8

// default select pins
`define BMS_DEF_PIN0 8'h18
`define BMS_DEF_PIN1 8'h20

// boot definition codes
`define BMS_DEF_SCI 8'h01
`define BMS_DEF_FLASH 8'h03
`define BMS_DEF_I2C 8'h07

// boot source pins and entry address
`define BMS_SCI_RX_PIN 8'h1D
`define BMS_SCI_TX_PIN 8'h1C
`define BMS_I2C_SDA_PIN 8'h20
`define BMS_I2C_SCL_PIN 8'h21
`define BMS_FLASH_ENTRY 32'h0008_0000

// reset values
`define BMS_PIN_RESET 32'h0000_0000
`define BMS_DEF_RESET 8'h00
`define BMS_CTRL_RESET 2'h0

`endif

// *** verilog/bms_pkg.sv ***
// types for the boot mode select block
`default_nettype none

package bms_pkg;

    typedef enum logic [1:0] {
        BMS_SRC_NONE = 2'b00,
        BMS_SRC_FLASH = 2'b01,
        BMS_SRC_SCI = 2'b10,
        BMS_SRC_I2C = 2'b11
    } bms_src_type;

    typedef struct packed {
        logic [7:0] key;
        logic [7:0] pin2;
        logic [7:0] pin1;
        logic [7:0] pin0;
    } bms_pinword_type;

    typedef struct packed {
        bms_src_type src;
        logic [7:0] pin_a;
        logic [7:0] pin_b;
        logic [31:0] entry;
    } bms_boot_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bms_bus_type;

endpackage

`default_nettype wire

// *** verilog/bms_pin_decode.sv ***
// decodes sampled pins into a boot mode index
`default_nettype none

`include "bms_consts.svh"

module bms_pin_decode (
    // pins and selection word
    input wire logic [255:0] i_pins,
    input wire bms_pkg::bms_pinword_type i_word,
    // result
    output logic [2:0] o_index,
    output logic o_custom
);
    import bms_pkg::*;

    logic [7:0] sel [3];

    always_comb begin
        o_custom = (i_word.key == `BMS_KEY_VALUE);
        if (o_custom) begin
            sel[0] = i_word.pin0;
            sel[1] = i_word.pin1;
            sel[2] = i_word.pin2;
        end else begin
            sel[0] = `BMS_DEF_PIN0;
            sel[1] = `BMS_DEF_PIN1;
            sel[2] = `BMS_DEF_PIN0;
        end
    end

    // default scheme uses two pins only, top bit forced low
    generate
        for (genvar b = 0; b < 3; b++) begin : g_bit
            if (b == 2) begin : g_top
                assign o_index[b] = o_custom & i_pins[sel[b]];
            end else begin : g_low
                assign o_index[b] = i_pins[sel[b]];
            end
        end
    endgenerate
endmodule

`default_nettype wire

// *** verilog/bms_mode_map.sv ***
// maps a boot mode index onto a boot source
`default_nettype none

`include "bms_consts.svh"

module bms_mode_map (
    // decoded mode
    input wire logic [2:0] i_index,
    input wire logic i_custom,
    input wire logic [7:0] i_entry,
    // boot choice
    output bms_pkg::bms_boot_type o_boot
);
    import bms_pkg::*;

    always_comb begin
        o_boot = '0;
        if (!i_custom) begin
            // default scheme: pin 24 low gives serial, both high flash
            if (!i_index[0]) begin
                o_boot.src = BMS_SRC_SCI;
                o_boot.pin_a = `BMS_SCI_RX_PIN;
                o_boot.pin_b = `BMS_SCI_TX_PIN;
            end else if (i_index[1]) begin
                o_boot.src = BMS_SRC_FLASH;
                o_boot.entry = `BMS_FLASH_ENTRY;
            end else begin
                o_boot.src = BMS_SRC_NONE;
            end
        end else begin
            unique case (i_entry)
                `BMS_DEF_SCI: begin
                    o_boot.src = BMS_SRC_SCI;
                    o_boot.pin_a = `BMS_SCI_RX_PIN;
                    o_boot.pin_b = `BMS_SCI_TX_PIN;
                end
                `BMS_DEF_FLASH: begin
                    o_boot.src = BMS_SRC_FLASH;
                    o_boot.entry = `BMS_FLASH_ENTRY;
                end
                `BMS_DEF_I2C: begin
                    o_boot.src = BMS_SRC_I2C;
                    o_boot.pin_a = `BMS_I2C_SDA_PIN;
                    o_boot.pin_b = `BMS_I2C_SCL_PIN;
                end
                // unknown codes boot nothing rather than guess
                default: begin
                    o_boot.src = BMS_SRC_NONE;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

// *** verilog/bms_top.sv ***
// boot mode select: pin sampling, tables and register port
//
// Function
// - default pins: GPIO 24 and 32 both high select flash boot
// - default pins: GPIO 24 low selects serial boot
// - without custom word, four modes from the two default pins
// - valid custom word: three chosen pins form a mode index, eight modes
// - word bits 7-0, 15-8, 23-16 each name one index bit's pin
// - fields used only with key 0x5A in bits 31-24, else default
// - entry 0x01 at index 1: serial boot on GPIO29/GPIO28
// - entry 0x03 at index 3: flash boot at 0x80000
// - entry 0x07 at index 7: I2C boot on GPIO32/GPIO33
// - writable trial copies of selection word and definition table
// - flash boot hands execution to the flash entry point
`default_nettype none

`include "bms_consts.svh"

module bms_top (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_resetn,
    // boot select pins
    input wire logic [255:0] i_pins,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    // boot choice
    output logic o_boot_valid,
    output logic [2:0] o_mode_index,
    output bms_pkg::bms_src_type o_boot_src,
    output logic [7:0] o_pin_a,
    output logic [7:0] o_pin_b,
    output logic [31:0] o_entry,
    output logic o_start
);
    import bms_pkg::*;

    // ----------------------------------------------------------------
    // register state
    // ----------------------------------------------------------------
    logic [31:0] fused_pin_select_word;
    logic [31:0] trial_pin_select_word;
    logic [7:0] trial_boot_definition_table [8];
    logic [7:0] boot_definition_table [8];
    logic [1:0] ctrl;
    logic [31:0] next_fused_pin;
    logic [31:0] next_trial_pin;
    logic [7:0] next_trial_def [8];
    logic [7:0] next_fused_def [8];
    logic [1:0] next_ctrl;
    logic [31:0] rdata;
    logic [31:0] next_rdata;

    // ctrl[0] picks trial copies, ctrl[1] requests a resample
    logic use_trial;
    assign use_trial = ctrl[0];

    // ----------------------------------------------------------------
    // sampling state
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        BMS_ST_RESET = 2'b00,
        BMS_ST_SAMPLE = 2'b01,
        BMS_ST_HOLD = 2'b10
    } bms_state_type;

    bms_state_type state;
    bms_state_type next_state;
    logic [2:0] index;
    logic [2:0] next_index;
    logic custom;
    logic next_custom;
    bms_boot_type boot;
    bms_boot_type next_boot;
    logic start;
    logic next_start;

    // ----------------------------------------------------------------
    // decode and map
    // ----------------------------------------------------------------
    bms_pinword_type word_sel;
    logic [2:0] dec_index;
    logic dec_custom;
    logic [7:0] entry_sel;
    bms_boot_type map_boot;

    assign word_sel = use_trial ? trial_pin_select_word
                                : fused_pin_select_word;

    bms_pin_decode u_decode (
        .i_pins(i_pins),
        .i_word(word_sel),
        .o_index(dec_index),
        .o_custom(dec_custom)
    );

    // the map works on the held index, so later writes cannot move it
    assign entry_sel = use_trial ? trial_boot_definition_table[index]
                                 : boot_definition_table[index];

    bms_mode_map u_map (
        .i_index(index),
        .i_custom(custom),
        .i_entry(entry_sel),
        .o_boot(map_boot)
    );

    // ----------------------------------------------------------------
    // register next values
    // ----------------------------------------------------------------
    always_comb begin
        next_fused_pin = fused_pin_select_word;
        next_trial_pin = trial_pin_select_word;
        next_trial_def = trial_boot_definition_table;
        next_fused_def = boot_definition_table;
        next_ctrl = {1'b0, ctrl[0]};
        next_rdata = '0;
        if (i_wr) begin
            unique case (i_addr)
                `BMS_OFS_FUSED_PIN: next_fused_pin = i_wdata;
                `BMS_OFS_TRIAL_PIN: next_trial_pin = i_wdata;
                `BMS_OFS_CTRL: next_ctrl = i_wdata[1:0];
                default: begin
                end
            endcase
            for (int e = 0; e < 8; e++) begin
                if (i_addr == `BMS_OFS_TRIAL_DEF + 8'(e * 4)) begin
                    next_trial_def[e] = i_wdata[7:0];
                end
                if (i_addr == `BMS_OFS_FUSED_DEF + 8'(e * 4)) begin
                    next_fused_def[e] = i_wdata[7:0];
                end
            end
        end
        if (i_rd) begin
            unique case (i_addr)
                `BMS_OFS_FUSED_PIN: next_rdata = fused_pin_select_word;
                `BMS_OFS_TRIAL_PIN: next_rdata = trial_pin_select_word;
                // resample bit is self-clearing, so it always reads 0
                `BMS_OFS_CTRL: next_rdata = {30'h0, 1'b0, ctrl[0]};
                `BMS_OFS_STATUS: next_rdata = {24'h0, 1'b0, boot.src,
                                               custom, index,
                                               state == BMS_ST_HOLD};
                default: next_rdata = '0;
            endcase
            for (int e = 0; e < 8; e++) begin
                if (i_addr == `BMS_OFS_TRIAL_DEF + 8'(e * 4)) begin
                    next_rdata = {24'h0, trial_boot_definition_table[e]};
                end
                if (i_addr == `BMS_OFS_FUSED_DEF + 8'(e * 4)) begin
                    next_rdata = {24'h0, boot_definition_table[e]};
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            fused_pin_select_word <= `BMS_PIN_RESET;
            trial_pin_select_word <= `BMS_PIN_RESET;
            for (int e = 0; e < 8; e++) begin
                trial_boot_definition_table[e] <= `BMS_DEF_RESET;
                boot_definition_table[e] <= `BMS_DEF_RESET;
            end
            ctrl <= `BMS_CTRL_RESET;
            rdata <= '0;
        end else begin
            fused_pin_select_word <= next_fused_pin;
            trial_pin_select_word <= next_trial_pin;
            trial_boot_definition_table <= next_trial_def;
            boot_definition_table <= next_fused_def;
            ctrl <= next_ctrl;
            rdata <= next_rdata;
        end
    end

    // ----------------------------------------------------------------
    // sampling sequence
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_index = index;
        next_custom = custom;
        next_boot = boot;
        next_start = 1'b0;
        unique case (state)
            BMS_ST_RESET: begin
                // first cycle after release: take the pins once
                next_index = dec_index;
                next_custom = dec_custom;
                next_state = BMS_ST_SAMPLE;
            end
            BMS_ST_SAMPLE: begin
                next_boot = map_boot;
                next_start = 1'b1;
                next_state = BMS_ST_HOLD;
            end
            BMS_ST_HOLD: begin
                // a ctrl[1] write resamples, trial copies or not; pins are otherwise ignored
                if (ctrl[1]) begin
                    next_state = BMS_ST_RESET;
                end
            end
            default: begin
                next_state = BMS_ST_RESET;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state <= BMS_ST_RESET;
            index <= 3'h0;
            custom <= 1'b0;
            boot <= '0;
            start <= 1'b0;
        end else begin
            state <= next_state;
            index <= next_index;
            custom <= next_custom;
            boot <= next_boot;
            start <= next_start;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign o_rdata = rdata;
    assign o_boot_valid = (state == BMS_ST_HOLD);
    assign o_mode_index = index;
    assign o_boot_src = boot.src;
    assign o_pin_a = boot.pin_a;
    assign o_pin_b = boot.pin_b;
    assign o_entry = boot.entry;
    assign o_start = start;
endmodule

`default_nettype wire

// *** dv/bms_board.sv ***
// board model strapping the boot select pins
`default_nettype none
module bms_board (
    // clock
    input wire logic i_clk,
    // wanted strap levels
    input wire logic [255:0] i_strap,
    // pins toward the device
    output logic [255:0] o_pins
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [255:0] strap_q = '0;
    // straps move just after an edge, like a jumper
    always @(posedge i_clk) begin
        strap_q <= i_strap;
    end
    assign o_pins = strap_q;
endmodule
`default_nettype wire

// *** dv/bms_top_checker.sv ***
// assertions on the boot mode select ports
`default_nettype none
`include "bms_consts.svh"
module bms_top_checker (
    // watched ports
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic [255:0] i_pins,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [31:0] o_rdata,
    input wire logic o_boot_valid,
    input wire logic [2:0] o_mode_index,
    input wire bms_pkg::bms_src_type o_boot_src,
    input wire logic [7:0] o_pin_a,
    input wire logic [7:0] o_pin_b,
    input wire logic [31:0] o_entry,
    input wire logic o_start
);
    timeunit 1ns;
    timeprecision 1ps;
    import bms_pkg::*;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);
    // second edge after release, when the choice lands
    sequence s_boot_edge;
        i_resetn && $past(i_resetn) && !$past(i_resetn, 2);
    endsequence
    a_default_flash: assert property (s_boot_edge ##0
        (i_pins[24] && i_pins[32]) |-> ##[1:2]
        (o_start && o_boot_src == BMS_SRC_FLASH))
        else $error("default pins did not pick flash");
    a_default_serial: assert property (s_boot_edge ##0 !i_pins[24]
        |-> ##[1:2] (o_start && o_boot_src == BMS_SRC_SCI))
        else $error("default pins did not pick serial");
    a_start_pulse: assert property (o_start |=> !o_start)
        else $error("start longer than one cycle");
    a_start_valid: assert property (o_start |-> o_boot_valid)
        else $error("start without valid");
    a_src_held: assert property ($changed(o_boot_src) &&
        $past(o_boot_valid) && o_boot_valid |-> o_start)
        else $error("boot source changed while held");
    a_flash_entry: assert property (o_boot_valid &&
        o_boot_src == BMS_SRC_FLASH |-> o_entry == `BMS_FLASH_ENTRY)
        else $error("flash entry wrong");
    a_serial_pins: assert property (o_boot_valid &&
        o_boot_src == BMS_SRC_SCI |-> o_pin_a == 8'h1D && o_pin_b == 8'h1C)
        else $error("serial pins wrong");
    a_i2c_pins: assert property (o_boot_valid &&
        o_boot_src == BMS_SRC_I2C |-> o_pin_a == 8'h20 && o_pin_b == 8'h21)
        else $error("i2c pins wrong");
    a_rdata_idle: assert property (!$past(i_rd) |->
        o_rdata == 32'h0)
        else $error("read data outside read slot");
endmodule
bind bms_top bms_top_checker chk_u (.*);
`default_nettype wire

// *** dv/test_boot_mode_select.sv ***
// self-checking bench for the boot mode select block
`default_nettype none
`include "bms_consts.svh"
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin \
    bad_count++; $display("MISMATCH t=%0t got %0h exp %0h", $time, got, \
    exp); end end
module test_boot_mode_select;
    timeunit 1ns;
    timeprecision 1ps;
    import bms_pkg::*;
    logic i_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic [255:0] want = 256'h1_0100_0000;
    logic [255:0] pins;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rdata;
    logic o_boot_valid;
    logic [2:0] o_mode_index;
    bms_src_type o_boot_src;
    logic [7:0] o_pin_a;
    logic [7:0] o_pin_b;
    logic [31:0] o_entry;
    logic o_start;
    int bad_count = 0;
    int samples_checked = 0;
    int cycles = 0;
    always #5 i_clk = ~i_clk;
    bms_board board_u (.i_clk(i_clk), .i_strap(want), .o_pins(pins));
    bms_top dut_u (.i_clk(i_clk), .i_resetn(i_resetn), .i_pins(pins),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .o_boot_valid(o_boot_valid),
        .o_mode_index(o_mode_index), .o_boot_src(o_boot_src),
        .o_pin_a(o_pin_a), .o_pin_b(o_pin_b), .o_entry(o_entry),
        .o_start(o_start));
    // ---------------------------------
    // bus and boot tasks
    // ---------------------------------
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        @(negedge i_clk);
        `CHK(o_rdata, e)
    endtask
    // waits for the start pulse, then checks the whole choice
    task automatic boot(input bms_src_type s, input logic [2:0] ix);
        int n;
        logic [7:0] pa;
        logic [7:0] pb;
        n = 0;
        pa = s == BMS_SRC_SCI ? 8'h1D : s == BMS_SRC_I2C ? 8'h20 : 8'h0;
        pb = s == BMS_SRC_SCI ? 8'h1C : s == BMS_SRC_I2C ? 8'h21 : 8'h0;
        while (o_start !== 1'b1 && n < 20) begin
            @(negedge i_clk);
            n++;
        end
        `CHK(o_start, 1'b1)
        `CHK(o_boot_valid, 1'b1)
        `CHK(o_boot_src, s)
        `CHK(o_mode_index, ix)
        `CHK(o_pin_a, pa)
        `CHK(o_pin_b, pb)
        `CHK(o_entry, s == BMS_SRC_FLASH ? 32'h0008_0000 : 32'h0)
        @(negedge i_clk);
        `CHK(o_start, 1'b0)
    endtask
    // ---------------------------------
    // tests
    // ---------------------------------
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            finish_test();
        end
    end
    initial begin
        repeat (10) @(posedge i_clk);
        i_resetn <= 1'b1;
        boot(BMS_SRC_FLASH, 3'h3);
        @(posedge i_clk);
        want[24] <= 1'b0;
        repeat (4) @(negedge i_clk);
        `CHK(o_boot_src, BMS_SRC_FLASH)
        $display("test 1 done");
        wr(8'h08, 32'h2);
        boot(BMS_SRC_SCI, 3'h2);
        want[24] <= 1'b1;
        want[32] <= 1'b0;
        wr(8'h08, 32'h2);
        boot(BMS_SRC_NONE, 3'h1);
        $display("test 2 done");
        wr(8'h00, 32'h5A07_0605);
        wr(8'h34, 32'h01);
        wr(8'h3C, 32'h03);
        wr(8'h4C, 32'h07);
        for (int k = 0; k < 4; k++) begin
            @(posedge i_clk);
            want[7:5] <= k == 0 ? 3'h1 : k == 1 ? 3'h3 : k == 2 ? 3'h7 : 3'h5;
            wr(8'h08, 32'h2);
            boot(k == 0 ? BMS_SRC_SCI : k == 1 ? BMS_SRC_FLASH :
                k == 2 ? BMS_SRC_I2C : BMS_SRC_NONE, want[7:5]);
        end
        want[7:5] <= 3'h7;
        wr(8'h08, 32'h2);
        boot(BMS_SRC_I2C, 3'h7);
        rd(8'h0C, 32'h7F);
        $display("test 3 done");
        want[32] <= 1'b1;
        wr(8'h00, 32'h5B07_0605);
        wr(8'h08, 32'h2);
        boot(BMS_SRC_FLASH, 3'h3);
        $display("test 4 done");
        want[10:8] <= 3'h1;
        wr(8'h04, 32'h5A0A_0908);
        wr(8'h14, 32'h01);
        rd(8'h04, 32'h5A0A_0908);
        rd(8'h14, 32'h01);
        wr(8'h08, 32'h3);
        boot(BMS_SRC_SCI, 3'h1);
        rd(8'h08, 32'h1);
        rd(8'hFC, 32'h0);
        $display("test 5 done");
        // second reset with pin 24 low: default scheme picks serial
        @(posedge i_clk);
        i_resetn <= 1'b0;
        want[24] <= 1'b0;
        repeat (3) @(posedge i_clk);
        i_resetn <= 1'b1;
        boot(BMS_SRC_SCI, 3'h2);
        rd(8'h04, 32'h0);
        rd(8'h08, 32'h0);
        $display("test 6 done");
        finish_test();
    end
endmodule
`default_nettype wire
